// ---- rtl/rtfr_regs.sv ----
// remote temperature fraction registers with coherent word read and fault-queue purge
`timescale 1ns/100ps
module rtfr_regs
  import rtfr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host command port, same clock
  input wire rtfr_req_t req,
  output rtfr_rsp_t rsp,
  // conversion result from the converter, same clock
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // toward comparison and fault-queue logic
  output rtfr_limits_t limits,
  output logic purge_high,
  output logic purge_low,
  output logic result_valid
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [11:0] result;
  logic [3:0] high_frac;
  logic [3:0] low_frac;
  logic [7:0] high_int;
  logic [7:0] low_int;
  logic have_result;
  logic [11:0] next_result;
  logic [3:0] next_high_frac;
  logic [3:0] next_low_frac;
  logic [7:0] next_high_int;
  logic [7:0] next_low_int;
  logic next_have_result;
  rtfr_rsp_t next_rsp;
  rtfr_limits_t next_limits;
  logic next_purge_high;
  logic next_purge_low;

  // place a fraction nibble in its byte with the reserved bits zero
  function automatic logic [7:0] frac_byte(input logic [3:0] nib);
    frac_byte = {nib, 4'h0};
  endfunction

  // ---------------------------------------------------------------
  // next-value logic
  // ---------------------------------------------------------------
  // the word read returns both halves of the same result register in one
  // cycle, so a conversion landing this cycle cannot split them
  always_comb begin
    next_result = result;
    next_have_result = have_result;
    next_high_frac = high_frac;
    next_low_frac = low_frac;
    next_high_int = high_int;
    next_low_int = low_int;
    next_purge_high = 1'b0;
    next_purge_low = 1'b0;
    next_rsp = '0;
    if (conv_done) begin
      next_result = conv_result;
      next_have_result = 1'b1;
    end
    if (req.wr && !req.word) begin
      case (req.cmd)
        CMD_HIGH_FRACTION: begin
          next_high_frac = req.wdata[FRAC_MSB:FRAC_LSB];
          next_purge_high = 1'b1;
        end
        CMD_LOW_FRACTION: begin
          next_low_frac = req.wdata[FRAC_MSB:FRAC_LSB];
          next_purge_low = 1'b1;
        end
        CMD_HIGH_INTEGER: begin
          next_high_int = req.wdata;
          next_purge_high = 1'b1;
        end
        CMD_LOW_INTEGER: begin
          next_low_int = req.wdata;
          next_purge_low = 1'b1;
        end
        default: begin
          next_purge_high = 1'b0; // writes elsewhere or to read-only codes are dropped
        end
      endcase
    end
    // reads answer from the registers as they stand, so a read beside a write returns the old value
    if (req.rd) begin
      next_rsp.valid = 1'b1;
      if (req.word) begin
        // only the result integer code answers a word read
        if (req.cmd == CMD_RESULT_INTEGER) begin
          next_rsp.first = result[11:4];
          next_rsp.second = frac_byte(result[3:0]);
        end else begin
          next_rsp.first = UNMAPPED_READ;
          next_rsp.second = UNMAPPED_READ;
        end
      end else begin
        case (req.cmd)
          CMD_RESULT_INTEGER: next_rsp.first = result[11:4];
          CMD_RESULT_FRACTION: next_rsp.first = frac_byte(result[3:0]);
          CMD_HIGH_FRACTION: next_rsp.first = frac_byte(high_frac);
          CMD_LOW_FRACTION: next_rsp.first = frac_byte(low_frac);
          CMD_HIGH_INTEGER: next_rsp.first = high_int;
          CMD_LOW_INTEGER: next_rsp.first = low_int;
          default: next_rsp.first = UNMAPPED_READ;
        endcase
      end
    end
    // limits are built from the next values, so they change on the same edge as the registers
    next_limits.high = {next_high_int, next_high_frac};
    next_limits.low = {next_low_int, next_low_frac};
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= RST_RESULT;
      have_result <= 1'b0;
      high_frac <= RST_FRACTION;
      low_frac <= RST_FRACTION;
      high_int <= RST_HIGH_INTEGER;
      low_int <= RST_LOW_INTEGER;
      rsp <= '0;
      limits <= {RST_HIGH_INTEGER, RST_FRACTION, RST_LOW_INTEGER, RST_FRACTION};
      purge_high <= 1'b0;
      purge_low <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      result <= next_result;
      have_result <= next_have_result;
      high_frac <= next_high_frac;
      low_frac <= next_low_frac;
      high_int <= next_high_int;
      low_int <= next_low_int;
      rsp <= next_rsp;
      limits <= next_limits;
      purge_high <= next_purge_high;
      purge_low <= next_purge_low;
      result_valid <= next_have_result;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_frac_write_high;
    req.wr && !req.word && req.cmd == CMD_HIGH_FRACTION;
  endsequence

  sequence s_frac_write_low;
    req.wr && !req.word && req.cmd == CMD_LOW_FRACTION;
  endsequence

  property p_result_lsn_zero;
    @(posedge clk) disable iff (!rst_b)
      req.rd && !req.word && req.cmd == CMD_RESULT_FRACTION |=> rsp.valid && rsp.first[3:0] == 4'h0;
  endproperty
  a_result_lsn_zero: assert property (p_result_lsn_zero) else $error("result fraction low nibble not zero");

  property p_no_data_before_conv;
    @(posedge clk) disable iff (!rst_b)
      !have_result |-> result == RST_RESULT;
  endproperty
  a_no_data_before_conv: assert property (p_no_data_before_conv) else $error("result changed before conversion");

  property p_byte_read_fraction;
    @(posedge clk) disable iff (!rst_b)
      req.rd && !req.word && req.cmd == CMD_RESULT_FRACTION |=> rsp.first == {$past(result[3:0]), 4'h0};
  endproperty
  a_byte_read_fraction: assert property (p_byte_read_fraction) else $error("fraction byte read wrong");

  property p_word_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.word && req.cmd == CMD_RESULT_INTEGER
      |=> rsp.first == $past(result[11:4]) && rsp.second == {$past(result[3:0]), 4'h0};
  endproperty
  a_word_read: assert property (p_word_read) else $error("word read halves wrong or split");

  property p_word_elsewhere;
    @(posedge clk) disable iff (!rst_b)
      req.rd && req.word && req.cmd != CMD_RESULT_INTEGER |=> rsp.first == UNMAPPED_READ && rsp.second == UNMAPPED_READ;
  endproperty
  a_word_elsewhere: assert property (p_word_elsewhere) else $error("word read answered at wrong code");

  property p_high_frac_write;
    @(posedge clk) disable iff (!rst_b)
      s_frac_write_high |=> high_frac == $past(req.wdata[7:4]) && limits.high[3:0] == $past(req.wdata[7:4]);
  endproperty
  a_high_frac_write: assert property (p_high_frac_write) else $error("high fraction write lost");

  property p_low_frac_write;
    @(posedge clk) disable iff (!rst_b)
      s_frac_write_low |=> low_frac == $past(req.wdata[7:4]);
  endproperty
  a_low_frac_write: assert property (p_low_frac_write) else $error("low fraction write lost");

  // limit writes and purge pulses
  property p_purge;
    @(posedge clk) disable iff (!rst_b)
      s_frac_write_high |=> purge_high && !purge_low;
  endproperty
  a_purge: assert property (p_purge) else $error("fault queue not purged");

  property p_purge_low;
    @(posedge clk) disable iff (!rst_b)
      s_frac_write_low |=> purge_low && !purge_high;
  endproperty
  a_purge_low: assert property (p_purge_low) else $error("low fault queue not purged");

  property p_purge_idle;
    @(posedge clk) disable iff (!rst_b)
      !(req.wr && !req.word) |=> !purge_high && !purge_low;
  endproperty
  a_purge_idle: assert property (p_purge_idle) else $error("purge without a limit write");

  property p_word_write_ignored;
    @(posedge clk) disable iff (!rst_b)
      req.wr && req.word |=> $stable(high_frac) && $stable(low_frac) && $stable(high_int) && $stable(low_int);
  endproperty
  a_word_write_ignored: assert property (p_word_write_ignored) else $error("word write changed a limit");

  property p_high_int_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && !req.word && req.cmd == CMD_HIGH_INTEGER |=> high_int == $past(req.wdata) && purge_high;
  endproperty
  a_high_int_write: assert property (p_high_int_write) else $error("high integer write lost");

  property p_low_int_write;
    @(posedge clk) disable iff (!rst_b)
      req.wr && !req.word && req.cmd == CMD_LOW_INTEGER |=> low_int == $past(req.wdata) && purge_low;
  endproperty
  a_low_int_write: assert property (p_low_int_write) else $error("low integer write lost");

  property p_limit_concat;
    @(posedge clk) disable iff (!rst_b)
      limits.high == {high_int, high_frac} && limits.low == {low_int, low_frac};
  endproperty
  a_limit_concat: assert property (p_limit_concat) else $error("limit not integer and nibble");

  // read answers stand exactly one cycle after the request
  property p_rsp_pulse;
    @(posedge clk) disable iff (!rst_b)
      !req.rd |=> !rsp.valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer without a read");

  property p_rd_valid;
    @(posedge clk) disable iff (!rst_b)
      req.rd |=> rsp.valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

  property p_byte_second_zero;
    @(posedge clk) disable iff (!rst_b)
      req.rd && !req.word |=> rsp.second == 8'h00;
  endproperty
  a_byte_second_zero: assert property (p_byte_second_zero) else $error("byte read carried a second byte");

  // integer byte sits directly above the sixteenths nibble
  property p_result_int_byte;
    @(posedge clk) disable iff (!rst_b)
      req.rd && !req.word && req.cmd == CMD_RESULT_INTEGER |=> rsp.first == $past(result[11:4]);
  endproperty
  a_result_int_byte: assert property (p_result_int_byte) else $error("integer byte misplaced");

  // result capture and hold
  property p_result_capture;
    @(posedge clk) disable iff (!rst_b)
      conv_done |=> result == $past(conv_result) && result_valid;
  endproperty
  a_result_capture: assert property (p_result_capture) else $error("conversion not captured");

  property p_result_hold;
    @(posedge clk) disable iff (!rst_b)
      !conv_done |=> result == $past(result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed without a conversion");

  property p_high_frac_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && !req.word && req.cmd == CMD_HIGH_FRACTION |=> rsp.first == {$past(high_frac), 4'h0};
  endproperty
  a_high_frac_read: assert property (p_high_frac_read) else $error("high fraction read wrong");

  property p_low_frac_read;
    @(posedge clk) disable iff (!rst_b)
      req.rd && !req.word && req.cmd == CMD_LOW_FRACTION |=> rsp.first == {$past(low_frac), 4'h0};
  endproperty
  a_low_frac_read: assert property (p_low_frac_read) else $error("low fraction read wrong");
endmodule

// ---- shared/rtfr_pkg.sv ----
// register map, field layout and carrier types for the remote fraction register slice
package rtfr_pkg;
  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RESULT_INTEGER = 8'h01;
  localparam logic [7:0] CMD_HIGH_INTEGER = 8'h07;
  localparam logic [7:0] CMD_LOW_INTEGER = 8'h08;
  localparam logic [7:0] CMD_RESULT_FRACTION = 8'h10;
  localparam logic [7:0] CMD_HIGH_FRACTION = 8'h13;
  localparam logic [7:0] CMD_LOW_FRACTION = 8'h14;
  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_HIGH_INTEGER = 8'h50;
  localparam logic [7:0] RST_LOW_INTEGER = 8'h00;
  localparam logic [3:0] RST_FRACTION = 4'h0;
  localparam logic [11:0] RST_RESULT = 12'h000;
  localparam int FRAC_MSB = 7;
  localparam int FRAC_LSB = 4;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // one fraction step is 1/16 degree, unsigned
  localparam int FRAC_STEPS_PER_DEGREE = 16;

  // host request toward the register slice
  typedef struct packed {
    logic wr;
    logic rd;
    logic word;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } rtfr_req_t;

  // answer back to the host
  typedef struct packed {
    logic valid;
    logic [7:0] first;
    logic [7:0] second;
  } rtfr_rsp_t;

  // limits toward the comparison logic
  typedef struct packed {
    logic [11:0] high;
    logic [11:0] low;
  } rtfr_limits_t;
endpackage

// ---- test/rtfr_host.sv ----
// host model issuing byte and word transfers to the register slice
`timescale 1ns/100ps
module rtfr_host
  import rtfr_pkg::*;
(
  // clock
  input wire logic clk,
  // command port
  output rtfr_req_t req,
  input wire rtfr_rsp_t rsp
);
  // idle code is unused so a stale command never aliases a register
  initial req = '{1'b0, 1'b0, 1'b0, 8'hee, 8'h00};
  // one-cycle write; the word flag is only raised to provoke a refusal
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic w);
    @(negedge clk) req <= '{1'b1, 1'b0, w, c, d};
    @(negedge clk) req <= '{1'b0, 1'b0, 1'b0, 8'hee, ~d};
  endtask
  // the word flag comes from the caller, so word reads can be issued at any code
  task automatic rd(input logic [7:0] c, input logic w, output rtfr_rsp_t r, output bit ok);
    ok = 0;
    @(negedge clk) req <= '{1'b0, 1'b1, w, c, 8'h00};
    @(negedge clk) req <= '{1'b0, 1'b0, 1'b0, 8'hee, 8'hff};
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rsp.valid === 1'b1) begin
        r = rsp;
        ok = 1;
      end else @(negedge clk);
    end
  endtask
endmodule

// ---- test/test_remote_temp_fraction_regs.sv ----
// self-checking bench for the remote fraction register slice
`timescale 1ns/100ps
module test_remote_temp_fraction_regs import rtfr_pkg::*;;
  logic clk = 0, rst_b = 0, conv_done = 0;
  logic [11:0] conv_result = 12'h000;
  rtfr_req_t req;
  rtfr_rsp_t rsp;
  rtfr_limits_t limits;
  logic purge_high, purge_low, result_valid;
  int n_errors = 0, n_compared = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  rtfr_regs i_rtfr_regs(.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp), .conv_done(conv_done),
    .conv_result(conv_result), .limits(limits), .purge_high(purge_high), .purge_low(purge_low),
    .result_valid(result_valid));
  rtfr_host i_rtfr_host(.clk(clk), .req(req), .rsp(rsp));
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // read and compare both bytes; a read with no answer ends the run
  task automatic rd(input logic [7:0] c, input logic w, input logic [15:0] exp);
    rtfr_rsp_t r;
    bit ok;
    i_rtfr_host.rd(c, w, r, ok);
    if (!ok) begin
      n_errors++;
      $display("mismatch at %0t: no read answer", $time);
      conclude();
    end else begin
      chk({r.first, r.second}, exp);
    end
  endtask
  // conversion pulse; the data bus shows junk once the pulse is over
  task automatic conv(input logic [11:0] v);
    @(negedge clk) conv_done = 1;
    conv_result = v;
    @(negedge clk) conv_done = 0;
    conv_result = ~v;
  endtask
  // values right after reset
  task automatic t_reset();
    chk(result_valid, 0);
    chk(limits.high, 12'h500);
    chk(limits.low, 12'h000);
    rd(CMD_RESULT_FRACTION, 0, 16'h0000);
    rd(CMD_HIGH_FRACTION, 0, 16'h0000);
    rd(CMD_LOW_FRACTION, 0, 16'h0000);
    rd(CMD_HIGH_INTEGER, 0, 16'h5000);
    rd(CMD_LOW_INTEGER, 0, 16'h0000);
  endtask
  // limit writes: reserved nibble dropped, purge pulse, 12-bit limits
  task automatic t_limits();
    // purge stands only until the next edge, so look as soon as the write returns
    i_rtfr_host.wr(CMD_HIGH_FRACTION, 8'hab, 0);
    chk({purge_high, purge_low}, 2'b10);
    chk(limits.high, 12'h50a);
    i_rtfr_host.wr(CMD_LOW_FRACTION, 8'h5f, 0);
    chk({purge_high, purge_low}, 2'b01);
    i_rtfr_host.wr(CMD_HIGH_INTEGER, 8'he1, 0);
    i_rtfr_host.wr(CMD_LOW_INTEGER, 8'h81, 0);
    @(negedge clk);
    chk(limits.high, 12'he1a);
    chk(limits.low, 12'h815);
    rd(CMD_HIGH_FRACTION, 0, 16'ha000);
    rd(CMD_LOW_FRACTION, 0, 16'h5000);
    rd(CMD_HIGH_INTEGER, 0, 16'he100);
    rd(CMD_LOW_INTEGER, 0, 16'h8100);
  endtask
  // conversion, byte and word reads, coherence when a conversion collides
  task automatic t_result();
    conv(12'h3c7);
    @(negedge clk);
    chk(result_valid, 1);
    rd(CMD_RESULT_FRACTION, 0, 16'h7000);
    rd(CMD_RESULT_INTEGER, 1, 16'h3c70);
    fork
      conv(12'h5a9);
      rd(CMD_RESULT_INTEGER, 1, 16'h3c70);
    join
    rd(CMD_RESULT_FRACTION, 0, 16'h9000);
    rd(CMD_RESULT_INTEGER, 1, 16'h5a90);
    rd(CMD_RESULT_INTEGER, 0, 16'h5a00);
  endtask
  // refused accesses leave state alone
  task automatic t_refused();
    rd(CMD_HIGH_FRACTION, 1, 16'h0000);
    i_rtfr_host.wr(CMD_RESULT_FRACTION, 8'hff, 0);
    chk({purge_high, purge_low}, 2'b00);
    i_rtfr_host.wr(CMD_HIGH_FRACTION, 8'h30, 1);
    chk({purge_high, purge_low}, 2'b00);
    rd(CMD_RESULT_FRACTION, 0, 16'h9000);
    rd(CMD_HIGH_FRACTION, 0, 16'ha000);
    rd(8'h55, 0, 16'h0000);
  endtask
  // main sequence, with a second reset in mid-run
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1;
    t_reset();
    t_limits();
    t_result();
    t_refused();
    @(negedge clk) rst_b = 0;
    repeat (2) @(negedge clk);
    rst_b = 1;
    t_reset();
    conclude();
  end
endmodule
